//--- verilog/fsr_pkg.sv
// Constants, types and state layout of the floppy status and output register bank.
// Assumes a 32-bit classic Wishbone slave port and a 40 MHz single clock.
// Overview of operation
// - Full mode: status A bit 0 is step direction, bit 3 is head side.
// - Full mode: status A bits 1, 2, 4 show write protect, index, track zero low.
// - Full mode: status A bit 7 is interrupt, bit 5 live step, bit 6 one.
// - Legacy mode: direction and head inverted; protect, index, track zero active high.
// - Legacy mode: status A bit 5 latches step; input-register read or resets clear it.
// - Legacy mode: bit 6 DMA request, bit 7 interrupt; bits 3, 0 reset high.
// - Full mode: status B bit 0 is motor 0; bits 0, 1 zero after reset.
// - Full mode: status B bit 2 is live write gate; bits 6, 7 read one.
// - Full mode: status B bits 3, 4 toggle on read and write data inactive edges.
// - Full mode: status B bit 5 mirrors output register drive select bit 0.
// - Legacy mode: status B latches write gate, read data, write data edges.
// - Legacy mode: status B bit 5 is drive select 0 low; bits 0, 1, 6 one.
// - Output register writable anytime; cleared by hardware reset, kept through soft reset.
// - Output register bit 2 at zero holds the controller in reset.
// - Soft reset lasts at least 100 ns; two back-to-back writes suffice.
// - Bit 3 gates DMA and interrupt in basic and legacy modes; always on in full.
// - Motor 0 output is the inverse of bit 4, ignoring drive select.
// - Drive select 0 low only when bit 4 is one and bits 1, 0 zero.
// - Tape select holds two bits, kept through soft reset; upper bits read empty.
package fsr_pkg;
    localparam int WB_ADR_W = 12;
    localparam int WB_DAT_W = 32;
    localparam logic [9:0] IDX_STATUS_A = 10'h3f0;
    localparam logic [9:0] IDX_STATUS_B = 10'h3f1;
    localparam logic [9:0] IDX_DRV_OUT = 10'h3f2;
    localparam logic [9:0] IDX_TAPE_SEL = 10'h3f3;
    localparam logic [7:0] DRV_OUT_RST = 8'h00;
    localparam logic [1:0] TAPE_SEL_RST = 2'h0;
    localparam int DOR_SEL0 = 0;
    localparam int DOR_SEL1 = 1;
    localparam int DOR_RESET_N = 2;
    localparam int DOR_DMA_EN = 3;
    localparam int DOR_MOTOR0 = 4;
    localparam int SYN_WP = 0;
    localparam int SYN_INDEX = 1;
    localparam int SYN_TRACK_ZERO_IN = 2;
    localparam int SYN_RDATA = 3;
    localparam int CLK_PERIOD_NS = 25;
    localparam int SRST_MIN_NS = 100;
    localparam logic [2:0] SRST_CYC = 3'((SRST_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

    typedef enum logic [1:0]
    {
        MODE_BASIC = 2'b00,
        MODE_FULL = 2'b01,
        MODE_LEGACY = 2'b10
    } fsr_mode_t;

    typedef struct packed
    {
        logic [7:0] drive_output_control;
        logic [1:0] tape_select;
        logic [2:0] rst_cnt;
        logic [3:0] sync1;
        logic [3:0] sync2;
        logic rd_prev;
        logic wd_prev;
        logic wg_prev;
        logic step_prev;
        logic rd_tgl;
        logic wd_tgl;
        logic step_ff;
        logic wg_ff;
        logic rd_ff;
        logic wd_ff;
        logic ack;
        logic [7:0] dat;
    } fsr_state_t;
endpackage

//--- verilog/fsr_regs.sv
// Floppy status A/B, drive output control and tape select registers behind a Wishbone slave.
// Assumes core signals arrive on clk_i; drive pins are asynchronous and are synchronised here.
`timescale 1ns/10ps
module fsr_regs
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire fsr_pkg::fsr_mode_t mode_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [fsr_pkg::WB_ADR_W-1:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [fsr_pkg::WB_DAT_W-1:0] wb_dat_i,
    output logic [fsr_pkg::WB_DAT_W-1:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic write_protect_n_i,
    input wire logic index_n_i,
    input wire logic track_zero_in_n_i,
    input wire logic read_data_n_i,
    input wire logic step_dir_in_i,
    input wire logic head_side_select_i,
    input wire logic step_i,
    input wire logic write_gate_i,
    input wire logic write_data_i,
    input wire logic fdc_irq_i,
    input wire logic dma_req_i,
    input wire logic din_reg_read_i,
    output logic motor0_out_n_o,
    output logic drive0_select_n_o,
    output logic ctrl_reset_o,
    output logic dma_irq_enable_o,
    output logic [1:0] tape_select_o
);
    import fsr_pkg::*;

    fsr_state_t s_reg;
    fsr_state_t s_next;
    logic soft_rst;
    logic req;
    logic [9:0] idx;
    logic [7:0] stat_a;
    logic [7:0] stat_b;
    logic rd_inact;
    logic wd_inact;
    logic wg_rise;
    logic step_rise;
    logic full_md;
    logic legacy_md;
    logic basic_md;

    always_comb
    begin
        full_md = 1'b0;
        legacy_md = 1'b0;
        basic_md = 1'b0;
        unique case (mode_i)
            MODE_FULL: full_md = 1'b1;
            MODE_LEGACY: legacy_md = 1'b1;
            MODE_BASIC: basic_md = 1'b1;
            default: basic_md = 1'b1;
        endcase
    end

    // The stretch counter keeps a one-write pulse of the reset bit long enough for the core.
    assign soft_rst = !s_reg.drive_output_control[DOR_RESET_N] || (s_reg.rst_cnt != 3'h0);
    assign ctrl_reset_o = soft_rst;
    assign motor0_out_n_o = !s_reg.drive_output_control[DOR_MOTOR0];
    assign drive0_select_n_o = !(s_reg.drive_output_control[DOR_MOTOR0] && !s_reg.drive_output_control[DOR_SEL1] && !s_reg.drive_output_control[DOR_SEL0]);
    assign dma_irq_enable_o = full_md || s_reg.drive_output_control[DOR_DMA_EN];
    assign tape_select_o = s_reg.tape_select;
    assign wb_ack_o = s_reg.ack;
    assign wb_dat_o = {24'h00_0000, s_reg.dat};

    assign req = wb_cyc_i && wb_stb_i;
    assign idx = wb_adr_i[WB_ADR_W-1:2];

    // The read data edge comes from the second synchroniser stage against a third held copy; the other edges compare the raw input against a registered copy.
    assign rd_inact = s_reg.sync2[SYN_RDATA] && !s_reg.rd_prev;
    assign wd_inact = !write_data_i && s_reg.wd_prev;
    assign wg_rise = write_gate_i && !s_reg.wg_prev;
    assign step_rise = step_i && !s_reg.step_prev;

    always_comb
    begin
        stat_a = 8'h00;
        stat_b = 8'h00;
        if (legacy_md)
        begin
            stat_a[0] = !step_dir_in_i;
            stat_a[1] = !s_reg.sync2[SYN_WP];
            stat_a[2] = !s_reg.sync2[SYN_INDEX];
            stat_a[3] = !head_side_select_i;
            stat_a[4] = !s_reg.sync2[SYN_TRACK_ZERO_IN];
            stat_a[5] = s_reg.step_ff;
            stat_a[6] = dma_req_i;
            stat_a[7] = fdc_irq_i;
            stat_b[0] = 1'b1;
            stat_b[1] = 1'b1;
            stat_b[2] = s_reg.wg_ff;
            stat_b[3] = s_reg.rd_ff;
            stat_b[4] = s_reg.wd_ff;
            stat_b[5] = drive0_select_n_o;
            stat_b[6] = 1'b1;
            stat_b[7] = 1'b1;
        end
        else
        begin
            stat_a[0] = step_dir_in_i;
            stat_a[1] = s_reg.sync2[SYN_WP];
            stat_a[2] = s_reg.sync2[SYN_INDEX];
            stat_a[3] = head_side_select_i;
            stat_a[4] = s_reg.sync2[SYN_TRACK_ZERO_IN];
            stat_a[5] = step_i;
            stat_a[6] = 1'b1;
            stat_a[7] = fdc_irq_i;
            stat_b[0] = s_reg.drive_output_control[DOR_MOTOR0];
            stat_b[1] = 1'b0;
            stat_b[2] = write_gate_i;
            stat_b[3] = s_reg.rd_tgl;
            stat_b[4] = s_reg.wd_tgl;
            stat_b[5] = s_reg.drive_output_control[DOR_SEL0];
            stat_b[6] = 1'b1;
            stat_b[7] = 1'b1;
        end
    end

    always_comb
    begin
        s_next = s_reg;
        s_next.sync1 = {read_data_n_i, track_zero_in_n_i, index_n_i, write_protect_n_i};
        s_next.sync2 = s_reg.sync1;
        s_next.rd_prev = s_reg.sync2[SYN_RDATA];
        s_next.wd_prev = write_data_i;
        s_next.wg_prev = write_gate_i;
        s_next.step_prev = step_i;

        if (!s_reg.drive_output_control[DOR_RESET_N])
        begin
            s_next.rst_cnt = SRST_CYC;
        end
        else if (s_reg.rst_cnt != 3'h0)
        begin
            s_next.rst_cnt = s_reg.rst_cnt - 3'h1;
        end

        if (rd_inact)
        begin
            s_next.rd_tgl = !s_reg.rd_tgl;
        end
        if (wd_inact)
        begin
            s_next.wd_tgl = !s_reg.wd_tgl;
        end

        // Clears come first so that an edge in the same cycle still sets the latch.
        if (din_reg_read_i)
        begin
            s_next.wg_ff = 1'b0;
            s_next.rd_ff = 1'b0;
            s_next.wd_ff = 1'b0;
        end
        if (din_reg_read_i || soft_rst)
        begin
            s_next.step_ff = 1'b0;
        end
        if (step_rise)
        begin
            s_next.step_ff = 1'b1;
        end
        if (wg_rise)
        begin
            s_next.wg_ff = 1'b1;
        end
        if (rd_inact)
        begin
            s_next.rd_ff = 1'b1;
        end
        if (wd_inact)
        begin
            s_next.wd_ff = 1'b1;
        end

        // Registered ack costs a cycle but keeps the bus path short.
        s_next.ack = req && !s_reg.ack;
        if (req && !s_reg.ack && !wb_we_i)
        begin
            s_next.dat = 8'h00;
            unique case (idx)
                IDX_STATUS_A: s_next.dat = basic_md ? 8'h00 : stat_a;
                IDX_STATUS_B: s_next.dat = basic_md ? 8'h00 : stat_b;
                IDX_DRV_OUT: s_next.dat = s_reg.drive_output_control;
                IDX_TAPE_SEL: s_next.dat = {6'h00, s_reg.tape_select};
                default: s_next.dat = 8'h00;
            endcase
        end
        if (req && s_reg.ack && wb_we_i && wb_sel_i[0])
        begin
            if (idx == IDX_DRV_OUT)
            begin
                s_next.drive_output_control = wb_dat_i[7:0];
            end
            if (idx == IDX_TAPE_SEL)
            begin
                s_next.tape_select = wb_dat_i[1:0];
            end
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            s_reg <= '0;
            s_reg.drive_output_control <= DRV_OUT_RST;
            s_reg.tape_select <= TAPE_SEL_RST;
            s_reg.rst_cnt <= SRST_CYC;
            s_reg.sync1 <= 4'hf;
            s_reg.sync2 <= 4'hf;
            s_reg.rd_prev <= 1'b1;
        end
        else
        begin
            s_reg <= s_next;
        end
    end
endmodule // fsr_regs

//--- tb/fsr_assertions.sv
// Port assertions for the floppy status and output register bank.
// Assumes it is bound into fsr_regs and sees only that module's ports.
`timescale 1ns/10ps
module fsr_assertions
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire fsr_pkg::fsr_mode_t mode_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [fsr_pkg::WB_ADR_W-1:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [fsr_pkg::WB_DAT_W-1:0] wb_dat_i,
    input wire logic [fsr_pkg::WB_DAT_W-1:0] wb_dat_o,
    input wire logic wb_ack_o,
    input wire logic motor0_out_n_o,
    input wire logic drive0_select_n_o,
    input wire logic ctrl_reset_o,
    input wire logic dma_irq_enable_o
);
    import fsr_pkg::*;
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    wire [9:0] ix = wb_adr_i[11:2];
    wire rd = wb_ack_o && !wb_we_i;
    wire wr = wb_ack_o && wb_we_i && wb_sel_i[0] && ix == IDX_DRV_OUT;
    sequence s_req; wb_cyc_i && wb_stb_i && !wb_ack_o; endsequence
    sequence s_pulse; wb_ack_o ##1 !wb_ack_o; endsequence
    property p_ack; s_req |=> s_pulse; endproperty
    a_ack: assert property (p_ack) else $error("ack not a single pulse");
    property p_sa; rd && ix == IDX_STATUS_A && mode_i == MODE_FULL |-> wb_dat_o[6]; endproperty
    a_sa: assert property (p_sa) else $error("status A bit 6 low");
    property p_sb; rd && ix == IDX_STATUS_B && mode_i == MODE_FULL |-> wb_dat_o[7:6] == 2'b11 && !wb_dat_o[1];
    endproperty
    a_sb: assert property (p_sb) else $error("status B fixed bits");
    property p_basic; rd && ix[9:1] == IDX_STATUS_A[9:1] && mode_i == MODE_BASIC |-> wb_dat_o == 32'h0000_0000;
    endproperty
    a_basic: assert property (p_basic) else $error("basic status read drove data");
    property p_tape; rd && ix == IDX_TAPE_SEL |-> wb_dat_o[31:2] == 30'h0000_0000; endproperty
    a_tape: assert property (p_tape) else $error("tape upper bits set");
    property p_mot; wr |=> motor0_out_n_o == !$past(wb_dat_i[DOR_MOTOR0]); endproperty
    a_mot: assert property (p_mot) else $error("motor output wrong");
    property p_sel; wr |=> drive0_select_n_o == !($past(wb_dat_i[4]) && $past(wb_dat_i[1:0]) == 2'b00); endproperty
    a_sel: assert property (p_sel) else $error("drive select decode wrong");
    property p_dma; mode_i == MODE_FULL |-> dma_irq_enable_o; endproperty
    a_dma: assert property (p_dma) else $error("full mode enable low");
    property p_srst; wr && !wb_dat_i[DOR_RESET_N] |=> ##[0:2] ctrl_reset_o; endproperty
    a_srst: assert property (p_srst) else $error("soft reset not raised");
    // A shorter pulse could be missed by a core running on a slower clock.
    property p_hold; $rose(ctrl_reset_o) |-> ctrl_reset_o [*4]; endproperty
    a_hold: assert property (p_hold) else $error("soft reset too short");
endmodule // fsr_assertions

//--- tb/fsr_drive_model.sv
// Behavioural floppy drive: active-low status pins and read data pulses.
// Assumes the bench asks for levels on the same clock; pins idle high.
`timescale 1ns/10ps
module fsr_drive_model
(
    input wire logic clk_i,
    input wire logic [2:0] state_i,
    input wire logic rd_pulse_i,
    output logic write_protect_n_o = 1'b1,
    output logic index_n_o = 1'b1,
    output logic track_zero_n_o = 1'b1,
    output logic read_data_n_o = 1'b1
);
    always @(posedge clk_i)
    begin
        write_protect_n_o <= !state_i[0];
        index_n_o <= !state_i[1];
        track_zero_n_o <= !state_i[2];
        read_data_n_o <= !rd_pulse_i;
    end
endmodule // fsr_drive_model

//--- tb/tb.sv
// Self-checking bench for the floppy status and output register bank.
// Assumes the package, fsr_regs, the drive model and the checker are compiled first.
`timescale 1ns/10ps
module tb;
    import fsr_pkg::*;
    logic clk = 0, rst = 1, cyc = 0, stb = 0, we = 0, rdp = 0;
    logic dir = 0, head = 0, step = 0, wg = 0, wd = 0, irq = 0, dma = 0, din = 0;
    fsr_mode_t mode = MODE_FULL;
    logic [11:0] adr = 0;
    logic [31:0] wdat = 0, rdat;
    logic [3:0] sel = 4'h0, bsel = 4'h1;
    logic [2:0] pins = 0;
    logic ack, mot_n, sel_n, crst, den, wp_n, idx_n, trk_n, rd_n;
    logic [1:0] tsel;
    logic [7:0] q;
    int bad_count = 0, samples_checked = 0, cycles = 0;
    fsr_regs fsr_regs_inst (.clk_i(clk), .rst_i(rst), .mode_i(mode), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
        .write_protect_n_i(wp_n), .index_n_i(idx_n), .track_zero_in_n_i(trk_n), .read_data_n_i(rd_n),
        .step_dir_in_i(dir), .head_side_select_i(head), .step_i(step), .write_gate_i(wg),
        .write_data_i(wd), .fdc_irq_i(irq), .dma_req_i(dma), .din_reg_read_i(din), .motor0_out_n_o(mot_n),
        .drive0_select_n_o(sel_n), .ctrl_reset_o(crst), .dma_irq_enable_o(den), .tape_select_o(tsel));
    fsr_drive_model fsr_drive_model_inst (.clk_i(clk), .state_i(pins), .rd_pulse_i(rdp),
        .write_protect_n_o(wp_n), .index_n_o(idx_n), .track_zero_n_o(trk_n), .read_data_n_o(rd_n));
    initial forever #12.5 clk = ~clk;
    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 5000)
        begin
            bad_count++;
            summarize();
        end
    end
    task automatic summarize;
        $display("checks %0d errors %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] s);
        samples_checked++;
        if (s !== e)
        begin
            $display("[ERR] %s expected %h seen %h", nm, e, s);
            bad_count++;
        end
    endtask
    task automatic bus(input logic w, input logic [9:0] ix, input logic [7:0] d);
        @(posedge clk);
        {cyc, stb, we, sel, adr, wdat} <= {2'b11, w, bsel, ix, 2'b00, 24'h00_0000, d};
        do @(posedge clk); while (ack !== 1'b1);
        q = rdat[7:0];
        {cyc, stb} <= 2'b00;
    endtask
    task automatic rd(input logic [9:0] ix, input logic [7:0] e, input string nm);
        bus(1'b0, ix, 8'h00);
        chk(nm, e, q);
    endtask
    task automatic pins_chk(input logic [7:0] e);
        repeat (8) @(posedge clk);
        chk("pins", e, {2'b00, tsel, den, crst, sel_n, mot_n});
    endtask
    task automatic hw_reset(input fsr_mode_t m);
        @(posedge clk);
        mode <= m;
        {rst, dir, head, step, wg, wd, irq, dma, din, pins} <= {1'b1, 11'h000};
        repeat (3) @(posedge clk);
        rst <= 1'b0;
    endtask
    task automatic t_full;
        rd(IDX_DRV_OUT, 8'h00, "dor");
        rd(IDX_STATUS_B, 8'hc0, "sb");
        bus(1'b1, IDX_DRV_OUT, 8'h1d);
        pins_chk(8'h0a);
        rd(IDX_STATUS_B, 8'he1, "sb");
        bus(1'b1, IDX_DRV_OUT, 8'h1c);
        pins_chk(8'h08);
        {dir, head, step, irq, wg, wd, rdp} <= 7'h7f;
        pins <= 3'b001;
        @(posedge clk);
        {wd, rdp} <= 2'b00;
        repeat (8) @(posedge clk);
        rd(IDX_STATUS_A, 8'hfd, "sa");
        rd(IDX_STATUS_B, 8'hdd, "sb");
    endtask
    task automatic t_soft;
        bus(1'b1, IDX_TAPE_SEL, 8'hff);
        pins_chk(8'h38);
        rd(IDX_TAPE_SEL, 8'h03, "tape");
        bus(1'b1, IDX_DRV_OUT, 8'h18);
        bus(1'b1, IDX_DRV_OUT, 8'h1c);
        pins_chk(8'h38);
        // A write without its byte lane must leave the output register alone.
        bsel = 4'h0;
        bus(1'b1, IDX_DRV_OUT, 8'h00);
        bsel = 4'h1;
        rd(IDX_DRV_OUT, 8'h1c, "dor");
        rd(IDX_TAPE_SEL, 8'h03, "tape");
        rd(IDX_STATUS_B, 8'hdd, "sb");
        bus(1'b1, IDX_TAPE_SEL, 8'h00);
    endtask
    task automatic t_legacy;
        hw_reset(MODE_LEGACY);
        rd(IDX_STATUS_A, 8'h09, "sa");
        rd(IDX_STATUS_B, 8'he3, "sb");
        pins_chk(8'h07);
        bus(1'b1, IDX_DRV_OUT, 8'h0c);
        pins_chk(8'h0b);
        {dir, head, step, dma, irq, wg, wd, rdp} <= 8'hff;
        pins <= 3'b001;
        @(posedge clk);
        {step, wg, wd, rdp} <= 4'h0;
        repeat (8) @(posedge clk);
        rd(IDX_STATUS_A, 8'he2, "sa");
        rd(IDX_STATUS_B, 8'hff, "sb");
        din <= 1'b1;
        @(posedge clk);
        din <= 1'b0;
        rd(IDX_STATUS_A, 8'hc2, "sa");
        rd(IDX_STATUS_B, 8'he3, "sb");
        step <= 1'b1;
        @(posedge clk);
        step <= 1'b0;
        rd(IDX_STATUS_A, 8'he2, "sa");
        bus(1'b1, IDX_DRV_OUT, 8'h18);
        bus(1'b1, IDX_DRV_OUT, 8'h1c);
        rd(IDX_STATUS_A, 8'hc2, "sa");
        rd(IDX_STATUS_B, 8'hc3, "sb");
    endtask
    task automatic t_basic;
        hw_reset(MODE_BASIC);
        rd(IDX_STATUS_A, 8'h00, "sa");
        rd(IDX_STATUS_B, 8'h00, "sb");
        rd(10'h3f7, 8'h00, "unmapped");
        pins_chk(8'h07);
        bus(1'b1, IDX_DRV_OUT, 8'h08);
        pins_chk(8'h0f);
        // The unused mode code must fall back to basic behaviour.
        hw_reset(fsr_mode_t'(2'b11));
        rd(IDX_STATUS_A, 8'h00, "sa");
    endtask
    initial
    begin
        hw_reset(MODE_FULL);
        pins_chk(8'h0f);
        t_full();
        t_soft();
        t_legacy();
        t_basic();
        summarize();
    end
endmodule // tb
bind fsr_regs fsr_assertions fsr_assertions_inst (.clk_i(clk_i), .rst_i(rst_i), .mode_i(mode_i),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
    .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .motor0_out_n_o(motor0_out_n_o),
    .drive0_select_n_o(drive0_select_n_o), .ctrl_reset_o(ctrl_reset_o), .dma_irq_enable_o(dma_irq_enable_o));
